// file: rtl/wakeup_pkg.sv
// constants and register map of the periodic wakeup counter
//
// Contract
// - tick count register reads the current count; writes to it are ignored
// - tick count clears on reset, wrap value write, or changed source/divider
// - with wrap value zero, flag sets on every prescaler output edge
// - reset loads wrap value with zero
// - any wrap value write clears prescaler and tick count
// - after reset counter stopped at zero, wrap zero, prescaler off
// - after reset the low-power oscillator is the selected source
// - prescaler off while divider select is zero; any nonzero code starts it
// - source select chooses oscillator, external or internal reference clock
// - source code 00 oscillator, 01 external, 1x internal reference
// - changed source select clears prescaler and count; same value does not
// - divide ratio set by divider select and source select low bit
// - divide table: binary and decimal ratios per source low bit; code 0 off
// - changed divider select clears prescaler and tick count
// - wrap value accepts any 8-bit setting
// - count advances per prescaler period to wrap value, then returns to zero
// - flag sets on the step from wrap value to zero
// - interrupt request asserted while flag and enable are both set
// - writing one to the flag bit clears flag and interrupt request
// - writing zero to flag bit does nothing; reset clears flag
package wakeup_pkg;
   localparam logic [11:0] CTRL_OFS     = 12'h000;
   localparam logic [11:0] COUNT_OFS    = 12'h004;
   localparam logic [11:0] WRAP_OFS     = 12'h008;
   localparam int          FLAG_BIT     = 7;
   localparam int          SRC_HI       = 6;
   localparam int          SRC_LO       = 5;
   localparam int          IRQEN_BIT    = 4;
   localparam int          DIV_HI       = 3;
   localparam logic [7:0]  WRAP_RST     = 8'h00;
   localparam logic [7:0]  COUNT_RST    = 8'h00;
   localparam logic [1:0]  SRC_RST      = 2'h0;
   localparam logic [3:0]  DIV_RST      = 4'h0;
   localparam int          PRE_W        = 18;

   typedef enum logic [1:0] {
      SRC_OSC = 2'b00,
      SRC_EXT = 2'b01,
      SRC_INT = 2'b10
   } src_t;

   // divide ratio for a divider code and source low bit; zero means off
   function automatic logic [PRE_W-1:0] div_ratio(input logic [3:0] code,
                                                   input logic       hi);
      logic [PRE_W-1:0] r;
      r = '0;
      if (!hi) begin
         unique case (code)
            4'd0: r = 18'd0;      4'd1: r = 18'd8;      4'd2: r = 18'd32;
            4'd3: r = 18'd64;     4'd4: r = 18'd128;    4'd5: r = 18'd256;
            4'd6: r = 18'd512;    4'd7: r = 18'd1024;   4'd8: r = 18'd1;
            4'd9: r = 18'd2;      4'd10: r = 18'd4;     4'd11: r = 18'd10;
            4'd12: r = 18'd16;    4'd13: r = 18'd100;   4'd14: r = 18'd500;
            4'd15: r = 18'd1000;
         endcase
      end else begin
         unique case (code)
            4'd0: r = 18'd0;      4'd1: r = 18'd1024;   4'd2: r = 18'd2048;
            4'd3: r = 18'd4096;   4'd4: r = 18'd8192;   4'd5: r = 18'd16384;
            4'd6: r = 18'd32768;  4'd7: r = 18'd65536;  4'd8: r = 18'd1000;
            4'd9: r = 18'd2000;   4'd10: r = 18'd5000;  4'd11: r = 18'd10000;
            4'd12: r = 18'd20000; 4'd13: r = 18'd50000; 4'd14: r = 18'd100000;
            4'd15: r = 18'd200000;
         endcase
      end
      return r;
   endfunction : div_ratio
endpackage : wakeup_pkg

// file: rtl/wakeup_prescaler.sv
// prescaler: counts source clock edges and emits one tick per divide period
`timescale 1ns/1ps
module wakeup_prescaler
   import wakeup_pkg::*;
(
   input  wire logic             i_mclk,   // system clock
   input  wire logic             i_rst_n,  // synchronised reset, active low
   input  wire logic             i_ce,     // clock enable
   input  wire logic             i_clr,    // clear prescaler count
   input  wire logic             i_edge,   // one rising edge of selected source
   input  wire logic [PRE_W-1:0] i_ratio,  // divide ratio, zero is off
   output logic                  o_tick    // one-cycle tick per period
);
   logic [PRE_W-1:0] cnt_q;

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_q  <= '0;
         o_tick <= 1'b0;
      end else if (i_ce) begin
         o_tick <= 1'b0;
         if (i_clr || i_ratio == '0) begin
            cnt_q <= '0;
         end else if (i_edge) begin
            if (cnt_q >= i_ratio - 18'd1) begin
               cnt_q  <= '0;
               o_tick <= 1'b1;
            end else begin
               cnt_q <= cnt_q + 18'd1;
            end
         end
      end
   end

   property p_off_quiet;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (i_ce && i_ratio == '0) |=> (cnt_q == '0);
   endproperty
   a_off_quiet: assert property (p_off_quiet) else $error("prescaler runs while off");

   property p_pre_clr;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (i_ce && i_clr) |=> (cnt_q == '0 && !o_tick);
   endproperty
   a_pre_clr: assert property (p_pre_clr) else $error("prescaler kept count on clear");
endmodule : wakeup_prescaler

// file: rtl/wakeup_counter.sv
// periodic wakeup counter with ahb-lite register slave
`timescale 1ns/1ps
module wakeup_counter
   import wakeup_pkg::*;
(
   input  wire logic        i_mclk,       // system clock 125 MHz
   input  wire logic        i_rst_n,      // async reset, active low
   input  wire logic        i_ce,         // clock enable, freezes state when low
   input  wire logic        i_osc_clk,    // low-power oscillator clock, async
   input  wire logic        i_ext_clk,    // external reference clock, async
   input  wire logic        i_int_clk,    // internal reference clock, async
   input  wire logic        i_hsel,       // slave select
   input  wire logic [11:0] i_haddr,      // byte address
   input  wire logic [1:0]  i_htrans,     // transfer type
   input  wire logic        i_hwrite,     // write when high
   input  wire logic [2:0]  i_hsize,      // transfer size
   input  wire logic        i_hready,     // bus ready in
   input  wire logic [31:0] i_hwdata,     // write data
   output logic [31:0]      o_hrdata,     // read data
   output logic             o_hreadyout,  // slave ready
   output logic             o_hresp,      // always okay
   output logic             o_irq         // wrap interrupt request
);
   import wakeup_pkg::*;

   logic [1:0]  rst_sync_q;
   logic        rst_n;
   logic [2:0]  osc_s_q;
   logic [2:0]  ext_s_q;
   logic [2:0]  int_s_q;
   logic        src_edge;
   logic        ph_wr_q;
   logic        ph_rd_q;
   logic [11:0] ph_addr_q;
   logic        wr_ctrl;
   logic        wr_wrap;
   logic        src_chg;
   logic        div_chg;
   logic        clr;
   logic [1:0]  src_q;
   logic [3:0]  div_q;
   logic        irq_en_q;
   logic        flag_q;
   logic [7:0]  wrap_q;
   logic [7:0]  count_q;
   logic        tick;
   logic        wrap_evt;
   logic [PRE_W-1:0] ratio;

   // reset release through two flops
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // source clocks: two sync flops then a third for edge detect
   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         osc_s_q <= 3'b000;
         ext_s_q <= 3'b000;
         int_s_q <= 3'b000;
      end else if (i_ce) begin
         osc_s_q <= {osc_s_q[1:0], i_osc_clk};
         ext_s_q <= {ext_s_q[1:0], i_ext_clk};
         int_s_q <= {int_s_q[1:0], i_int_clk};
      end
   end

   // source mux
   always_comb begin
      unique casez (src_q)
         2'b00:   src_edge = osc_s_q[1] & ~osc_s_q[2];
         2'b01:   src_edge = ext_s_q[1] & ~ext_s_q[2];
         default: src_edge = int_s_q[1] & ~int_s_q[2];
      endcase
   end

   assign ratio = div_ratio(div_q, src_q[0]);

   // ahb-lite address phase capture; zero wait states
   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         ph_wr_q   <= 1'b0;
         ph_rd_q   <= 1'b0;
         ph_addr_q <= 12'h000;
      end else if (i_ce) begin
         if (i_hready) begin
            ph_wr_q   <= i_hsel && i_htrans[1] && i_hwrite;
            ph_rd_q   <= i_hsel && i_htrans[1] && !i_hwrite;
            ph_addr_q <= i_haddr;
         end
      end
   end

   assign wr_ctrl = ph_wr_q && ph_addr_q[11:2] == CTRL_OFS[11:2];
   assign wr_wrap = ph_wr_q && ph_addr_q[11:2] == WRAP_OFS[11:2];
   assign src_chg = wr_ctrl && i_hwdata[SRC_HI:SRC_LO] != src_q;
   assign div_chg = wr_ctrl && i_hwdata[DIV_HI:0] != div_q;
   assign clr     = wr_wrap || src_chg || div_chg;

   // control fields
   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         src_q    <= SRC_RST;
         div_q    <= DIV_RST;
         irq_en_q <= 1'b0;
      end else if (i_ce && wr_ctrl) begin
         src_q    <= i_hwdata[SRC_HI:SRC_LO];
         div_q    <= i_hwdata[DIV_HI:0];
         irq_en_q <= i_hwdata[IRQEN_BIT];
      end
   end

   // wrap value, full 8-bit range
   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         wrap_q <= WRAP_RST;
      end else if (i_ce && wr_wrap) begin
         wrap_q <= i_hwdata[7:0];
      end
   end

   wakeup_prescaler u_pre (
      .i_mclk  (i_mclk),
      .i_rst_n (rst_n),
      .i_ce    (i_ce),
      .i_clr   (clr),
      .i_edge  (src_edge),
      .i_ratio (ratio),
      .o_tick  (tick)
   );

   assign wrap_evt = tick && count_q == wrap_q;

   // tick counter; writes to its own address are ignored
   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= COUNT_RST;
      end else if (i_ce) begin
         if (clr) begin
            count_q <= COUNT_RST;
         end else if (tick) begin
            count_q <= wrap_evt ? COUNT_RST : count_q + 8'd1;
         end
      end
   end

   // wrap flag: set wins over clear
   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         flag_q <= 1'b0;
      end else if (i_ce) begin
         if (wrap_evt) begin
            flag_q <= 1'b1;
         end else if (wr_ctrl && i_hwdata[FLAG_BIT]) begin
            flag_q <= 1'b0;
         end
      end
   end

   // interrupt output, registered
   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         o_irq <= 1'b0;
      end else if (i_ce) begin
         o_irq <= flag_q && irq_en_q;
      end
   end

   // read data registered at the address phase
   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         o_hrdata <= 32'h0000_0000;
      end else if (i_ce) begin
         o_hrdata <= 32'h0000_0000;
         if (i_hready && i_hsel && i_htrans[1] && !i_hwrite) begin
            unique case (i_haddr[11:2])
               CTRL_OFS[11:2]:  o_hrdata <= {24'h00_0000, flag_q, src_q, irq_en_q, div_q};
               COUNT_OFS[11:2]: o_hrdata <= {24'h00_0000, count_q};
               WRAP_OFS[11:2]:  o_hrdata <= {24'h00_0000, wrap_q};
               default:         o_hrdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         o_hreadyout <= 1'b1;
         o_hresp     <= 1'b0;
      end else begin
         o_hreadyout <= 1'b1;
         o_hresp     <= 1'b0;
      end
   end

   sequence s_wrap_write;
      i_ce && wr_wrap;
   endsequence
   sequence s_zero_count;
      count_q == 8'h00;
   endsequence

   property p_count_ro;
      @(posedge i_mclk) disable iff (!rst_n)
      (i_ce && ph_wr_q && ph_addr_q[11:2] == COUNT_OFS[11:2] && !tick)
         |=> count_q == $past(count_q);
   endproperty
   a_count_ro: assert property (p_count_ro) else $error("count changed by write");

   property p_wrap_clr;
      @(posedge i_mclk) disable iff (!rst_n)
      s_wrap_write |=> s_zero_count;
   endproperty
   a_wrap_clr: assert property (p_wrap_clr) else $error("wrap write kept count");

   property p_src_clr;
      @(posedge i_mclk) disable iff (!rst_n)
      (i_ce && src_chg) |=> count_q == 8'h00;
   endproperty
   a_src_clr: assert property (p_src_clr) else $error("source change kept count");

   property p_div_clr;
      @(posedge i_mclk) disable iff (!rst_n)
      (i_ce && div_chg) |=> count_q == 8'h00 && div_q == $past(i_hwdata[DIV_HI:0]);
   endproperty
   a_div_clr: assert property (p_div_clr) else $error("divider change kept count");

   property p_zero_wrap;
      @(posedge i_mclk) disable iff (!rst_n)
      (i_ce && tick && wrap_q == 8'h00) |=> flag_q;
   endproperty
   a_zero_wrap: assert property (p_zero_wrap) else $error("flag missed at wrap zero");

   property p_flag_step;
      @(posedge i_mclk) disable iff (!rst_n)
      $rose(flag_q) |-> $past(wrap_evt);
   endproperty
   a_flag_step: assert property (p_flag_step) else $error("flag rose without wrap");

   property p_wrap_seq;
      @(posedge i_mclk) disable iff (!rst_n)
      (i_ce && tick && !clr && count_q == wrap_q) |=> flag_q && count_q == 8'h00;
   endproperty
   a_wrap_seq: assert property (p_wrap_seq) else $error("wrap step wrong");

   property p_count_step;
      @(posedge i_mclk) disable iff (!rst_n)
      (i_ce && tick && !clr && count_q != wrap_q) |=> count_q == $past(count_q) + 8'd1;
   endproperty
   a_count_step: assert property (p_count_step) else $error("count did not advance");

   property p_irq;
      @(posedge i_mclk) disable iff (!rst_n)
      i_ce |=> o_irq == $past(flag_q && irq_en_q);
   endproperty
   a_irq: assert property (p_irq) else $error("irq mismatch");

   property p_set_wins;
      @(posedge i_mclk) disable iff (!rst_n)
      (i_ce && wrap_evt && wr_ctrl && i_hwdata[FLAG_BIT]) |=> flag_q;
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("event lost on clear");

   property p_flag_clr;
      @(posedge i_mclk) disable iff (!rst_n)
      (i_ce && !wrap_evt && wr_ctrl && i_hwdata[FLAG_BIT]) |=> !flag_q ##1 !o_irq;
   endproperty
   a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");

   // freeze, bus and reset behaviour
   property p_freeze;
      @(posedge i_mclk) disable iff (!rst_n)
      !i_ce |=> count_q == $past(count_q) && flag_q == $past(flag_q)
                && wrap_q == $past(wrap_q);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while frozen");

   property p_bus_okay;
      @(posedge i_mclk) disable iff (!rst_n)
      o_hreadyout && !o_hresp;
   endproperty
   a_bus_okay: assert property (p_bus_okay) else $error("bus not ready or not okay");

   property p_rdata_idle;
      @(posedge i_mclk) disable iff (!rst_n)
      (i_ce && !(i_hready && i_hsel && i_htrans[1] && !i_hwrite)) |=> o_hrdata == 32'h0000_0000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside data phase");

   property p_reset_vals;
      @(posedge i_mclk)
      !rst_n |-> count_q == COUNT_RST && wrap_q == WRAP_RST && div_q == DIV_RST
                 && src_q == SRC_RST && !flag_q;
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

   property p_zero_write;
      @(posedge i_mclk) disable iff (!rst_n)
      (i_ce && wr_ctrl && !i_hwdata[FLAG_BIT] && flag_q) |=> flag_q;
   endproperty
   a_zero_write: assert property (p_zero_write) else $error("zero write cleared flag");

   property p_same_keep;
      @(posedge i_mclk) disable iff (!rst_n)
      (i_ce && wr_ctrl && !src_chg && !div_chg && !tick) |=> count_q == $past(count_q);
   endproperty
   a_same_keep: assert property (p_same_keep) else $error("same rewrite cleared count");

   property p_wrap_load;
      @(posedge i_mclk) disable iff (!rst_n)
      (i_ce && wr_wrap) |=> wrap_q == $past(i_hwdata[7:0]);
   endproperty
   a_wrap_load: assert property (p_wrap_load) else $error("wrap value not loaded");

   property p_src_load;
      @(posedge i_mclk) disable iff (!rst_n)
      (i_ce && wr_ctrl) |=> src_q == $past(i_hwdata[SRC_HI:SRC_LO]);
   endproperty
   a_src_load: assert property (p_src_load) else $error("source not loaded");

   property p_off_idle;
      @(posedge i_mclk) disable iff (!rst_n)
      div_q == 4'h0 |-> !tick;
   endproperty
   a_off_idle: assert property (p_off_idle) else $error("tick while prescaler off");

   property p_wrap_bound;
      @(posedge i_mclk) disable iff (!rst_n)
      count_q <= wrap_q;
   endproperty
   a_wrap_bound: assert property (p_wrap_bound) else $error("count passed wrap value");

   sequence s_wrap_step;
      i_ce && tick && !clr && count_q == wrap_q;
   endsequence

   property p_irq_follow;
      @(posedge i_mclk) disable iff (!rst_n)
      (s_wrap_step ##1 (i_ce && irq_en_q)) |=> o_irq;
   endproperty
   a_irq_follow: assert property (p_irq_follow) else $error("irq missed after wrap");
endmodule : wakeup_counter

// file: testbench/periodic_wakeup_counter_bench.sv
// self-checking bench for the periodic wakeup counter
`timescale 1ns/1ps
module periodic_wakeup_counter_bench;
   import wakeup_pkg::*;
   logic        i_mclk      = 1'b0;
   logic        i_rst_n     = 1'b0;
   logic        ce          = 1'b1;
   logic [2:0]  src_clks    = 3'b000;
   logic        i_hsel      = 1'b0;
   logic [11:0] i_haddr     = 12'h000;
   logic [1:0]  i_htrans    = 2'b00;
   logic        i_hwrite    = 1'b0;
   logic [31:0] i_hwdata    = 32'h0000_0000;
   logic [31:0] o_hrdata;
   logic        o_hreadyout;
   logic        o_hresp;
   logic        o_irq;
   logic [31:0] rdv;
   int          error_cnt   = 0;
   int          checks_done = 0;
   int          rat0 [1:15] = '{8, 32, 64, 128, 256, 512, 1024, 1, 2, 4, 10, 16, 100, 500, 1000};

   wakeup_counter DUT (
      .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(ce),
      .i_osc_clk(src_clks[0]), .i_ext_clk(src_clks[1]), .i_int_clk(src_clks[2]),
      .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
      .i_hsize(3'b010), .i_hready(o_hreadyout), .i_hwdata(i_hwdata),
      .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_irq(o_irq));

   always #4 i_mclk = ~i_mclk;

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // single ahb-lite transfer; read data lands in rdv
   task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge i_mclk);
      i_hsel   <= 1'b1;
      i_htrans <= 2'b10;
      i_haddr  <= a;
      i_hwrite <= wr;
      do @(posedge i_mclk); while (o_hreadyout !== 1'b1);
      i_hsel   <= 1'b0;
      i_htrans <= 2'b00;
      i_hwdata <= wd;
      do @(posedge i_mclk); while (o_hreadyout !== 1'b1);
      rdv = o_hrdata;
   endtask : ahb

   task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string nm);
      ahb(1'b0, a, 32'h0000_0000);
      chk(nm, exp, rdv);
   endtask : rdc

   // n rising edges on one source clock, then let them pass the synchroniser
   task automatic pulse(input int sel, input int n);
      repeat (n) begin
         @(posedge i_mclk);
         src_clks[sel] <= 1'b1;
         repeat (3) @(posedge i_mclk);
         src_clks[sel] <= 1'b0;
         repeat (2) @(posedge i_mclk);
      end
      repeat (8) @(posedge i_mclk);
   endtask : pulse

   function automatic logic [31:0] ctl(input logic f, input logic [1:0] s, input logic e,
                                       input logic [3:0] d);
      return {24'h00_0000, f, s, e, d};
   endfunction : ctl

   task automatic do_reset;
      i_rst_n <= 1'b0;
      repeat (5) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      repeat (3) @(posedge i_mclk);
   endtask : do_reset

   task automatic reset_state;
      rdc(CTRL_OFS, 32'h0000_0000, "ctrl");
      rdc(COUNT_OFS, 32'h0000_0000, "count");
      rdc(WRAP_OFS, 32'h0000_0000, "wrap");
      chk("irq", 32'h0000_0000, {31'h0, o_irq});
      chk("hresp", 32'h0000_0000, {31'h0, o_hresp});
      chk("hreadyout", 32'h0000_0001, {31'h0, o_hreadyout});
   endtask : reset_state

   task automatic print_verdict;
      if (error_cnt == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : print_verdict

   initial begin
      repeat (80000) @(posedge i_mclk);
      error_cnt++;
      print_verdict();
   end

   initial begin
      do_reset();
      reset_state();
      rdc(12'h00C, 32'h0000_0000, "unmapped");
      pulse(0, 4);
      rdc(COUNT_OFS, 32'h0000_0000, "count while off");
      ahb(1'b1, WRAP_OFS, 32'h0000_0003);
      ahb(1'b1, CTRL_OFS, ctl(0, 2'b00, 0, 4'h8));
      pulse(0, 2);
      rdc(COUNT_OFS, 32'h0000_0002, "count osc");
      ahb(1'b1, COUNT_OFS, 32'h0000_0055);
      rdc(COUNT_OFS, 32'h0000_0002, "count after write");
      // clock enable low: a source edge must not be counted
      ce <= 1'b0;
      pulse(0, 1);
      ce <= 1'b1;
      rdc(COUNT_OFS, 32'h0000_0002, "count frozen");
      pulse(0, 1);
      rdc(COUNT_OFS, 32'h0000_0003, "count at match");
      rdc(CTRL_OFS, ctl(0, 2'b00, 0, 4'h8), "flag at match");
      pulse(0, 1);
      rdc(COUNT_OFS, 32'h0000_0000, "count wrapped");
      rdc(CTRL_OFS, ctl(1, 2'b00, 0, 4'h8), "flag on wrap");
      chk("irq disabled", 32'h0000_0000, {31'h0, o_irq});
      ahb(1'b1, CTRL_OFS, ctl(0, 2'b00, 1, 4'h8));
      repeat (3) @(posedge i_mclk);
      chk("irq enabled", 32'h0000_0001, {31'h0, o_irq});
      rdc(CTRL_OFS, ctl(1, 2'b00, 1, 4'h8), "flag kept");
      ahb(1'b1, CTRL_OFS, ctl(1, 2'b00, 1, 4'h8));
      repeat (3) @(posedge i_mclk);
      chk("irq cleared", 32'h0000_0000, {31'h0, o_irq});
      rdc(CTRL_OFS, ctl(0, 2'b00, 1, 4'h8), "flag cleared");
      pulse(0, 2);
      ahb(1'b1, CTRL_OFS, ctl(0, 2'b00, 1, 4'h8));
      rdc(COUNT_OFS, 32'h0000_0002, "same rewrite");
      ahb(1'b1, WRAP_OFS, 32'h0000_00FF);
      rdc(COUNT_OFS, 32'h0000_0000, "wrap write clear");
      rdc(WRAP_OFS, 32'h0000_00FF, "wrap max");
      for (int c = 1; c < 16; c++) begin
         ahb(1'b1, CTRL_OFS, ctl(0, 2'b00, 0, c[3:0]));
         rdc(COUNT_OFS, 32'h0000_0000, "div change clear");
         pulse(0, rat0[c] - 1);
         rdc(COUNT_OFS, 32'h0000_0000, "div early");
         pulse(0, 1);
         rdc(COUNT_OFS, 32'h0000_0001, "div tick");
      end
      ahb(1'b1, CTRL_OFS, ctl(0, 2'b10, 0, 4'hF));
      rdc(COUNT_OFS, 32'h0000_0000, "src change clear");
      ahb(1'b1, CTRL_OFS, ctl(0, 2'b10, 0, 4'h8));
      pulse(0, 3);
      rdc(COUNT_OFS, 32'h0000_0000, "osc not selected");
      pulse(2, 2);
      rdc(COUNT_OFS, 32'h0000_0002, "int source");
      ahb(1'b1, CTRL_OFS, ctl(0, 2'b01, 0, 4'h8));
      pulse(1, 999);
      rdc(COUNT_OFS, 32'h0000_0000, "ext early");
      pulse(1, 1);
      rdc(COUNT_OFS, 32'h0000_0001, "ext tick");
      ahb(1'b1, CTRL_OFS, ctl(0, 2'b11, 0, 4'h8));
      rdc(COUNT_OFS, 32'h0000_0000, "src 11 clear");
      pulse(2, 1000);
      rdc(COUNT_OFS, 32'h0000_0001, "int hi tick");
      ahb(1'b1, CTRL_OFS, ctl(0, 2'b00, 1, 4'h8));
      ahb(1'b1, WRAP_OFS, 32'h0000_0000);
      pulse(0, 1);
      rdc(CTRL_OFS, ctl(1, 2'b00, 1, 4'h8), "wrap zero flag");
      rdc(COUNT_OFS, 32'h0000_0000, "wrap zero count");
      ahb(1'b1, CTRL_OFS, ctl(1, 2'b00, 1, 4'h8));
      pulse(0, 1);
      rdc(CTRL_OFS, ctl(1, 2'b00, 1, 4'h8), "wrap zero again");
      chk("irq wrap zero", 32'h0000_0001, {31'h0, o_irq});
      // clear the flag, then land a clearing write on the cycle of a new wrap
      ahb(1'b1, CTRL_OFS, ctl(1, 2'b00, 1, 4'h8));
      @(posedge i_mclk);
      src_clks[0] <= 1'b1;
      @(posedge i_mclk);
      ahb(1'b1, CTRL_OFS, ctl(1, 2'b00, 1, 4'h8));
      src_clks[0] <= 1'b0;
      repeat (8) @(posedge i_mclk);
      rdc(CTRL_OFS, ctl(1, 2'b00, 1, 4'h8), "set wins");
      do_reset();
      reset_state();
      print_verdict();
   end
endmodule : periodic_wakeup_counter_bench
